/* rtl/gppc_port0.sv */
/*
 * seven-pin general port 0 with AXI4-Lite register access.
 * assumes one clock, synchronous active-low reset, and an outside pad that
 * resolves PIN_OUT/PIN_OE and applies PIN_PULLUP.
 */
// Notes on behaviour
// RULE1: output port mode drives latch, reads latch
// RULE2: input mode: write latch only, read pin
// RULE3: alternate output read shows function or latch
// RULE4: alternate mode: peripheral owns pin, latch writable
// RULE5: latch keeps value until next write
// RULE6: direction bit per pin, 0 output
// RULE7: function-mode bit per pin, 1 alternate
// RULE8: per-pin selection bit picks alternate function
// RULE9: per-pin extension bit widens that choice
// RULE10: output-type bit, 1 open drain, resets zero
// RULE11: output type only matters in output direction
// RULE12: pull-up enable per pin, resets zero
// RULE13: software sets selection before function mode
// RULE14: every bit singly readable and writable
// RULE15: port 0 has seven pins
// RULE16: pin 0 drives low after reset
// RULE17: port 0 alternate routing: timer, nmi, irqs
// RULE18: pin levels pass two flip-flops first
`include "gppc_cfg.svh"
`default_nettype none

module gppc_port0 (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // write address and data
  input wire gppc_pkg::gppc_addr_t AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  // write response
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  // read
  input wire gppc_pkg::gppc_addr_t ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  // pins
  input wire gppc_pkg::gppc_pins_t PIN_IN,
  output gppc_pkg::gppc_pins_t PIN_OUT,
  output gppc_pkg::gppc_pins_t PIN_OE,
  output gppc_pkg::gppc_pins_t PIN_PULLUP,
  // alternate functions
  input wire logic [1:0] TMR_H_OUT,
  output logic NMI_IN,
  output logic [3:0] EXT_IRQ_IN
);
  import gppc_pkg::*;

  // ***********************************
  // pin synchroniser
  // ***********************************
  gppc_pins_t pin_m_r;
  gppc_pins_t pin_s_r;

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      pin_m_r <= `GPPC_RST_ZERO;
      pin_s_r <= `GPPC_RST_ZERO;
    end else begin
      pin_m_r <= PIN_IN; // RULE18
      pin_s_r <= pin_m_r;
    end
  end

  // ***********************************
  // write channel
  // ***********************************
  logic aw_held_r, aw_held_nxt, w_held_r, w_held_nxt;
  logic awready_r, awready_nxt, wready_r, wready_nxt;
  logic bvalid_r, bvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt;
  gppc_addr_t aw_addr_r, aw_addr_nxt;
  logic [31:0] w_data_r, w_data_nxt;
  logic w_strb_r, w_strb_nxt;
  logic do_wr, wr_hit;

  assign do_wr = aw_held_r & w_held_r;

  always_comb begin
    aw_addr_nxt = aw_addr_r;
    w_data_nxt = w_data_r;
    w_strb_nxt = w_strb_r;
    aw_held_nxt = aw_held_r;
    w_held_nxt = w_held_r;
    if (AWVALID & awready_r) begin
      aw_held_nxt = 1'b1;
      aw_addr_nxt = AWADDR;
    end
    if (WVALID & wready_r) begin
      w_held_nxt = 1'b1;
      w_data_nxt = WDATA;
      w_strb_nxt = WSTRB[0];
    end
    bvalid_nxt = bvalid_r & ~BREADY;
    bresp_nxt = bresp_r;
    if (do_wr) begin
      aw_held_nxt = 1'b0;
      w_held_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = wr_hit ? `GPPC_RESP_OKAY : `GPPC_RESP_SLVERR;
    end
    // one write at a time: hold both channels until the answer is taken
    awready_nxt = ~aw_held_nxt & ~bvalid_nxt;
    wready_nxt = ~w_held_nxt & ~bvalid_nxt;
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= `GPPC_RESP_OKAY;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 1'b0;
    end else begin
      aw_held_r <= aw_held_nxt;
      w_held_r <= w_held_nxt;
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      aw_addr_r <= aw_addr_nxt;
      w_data_r <= w_data_nxt;
      w_strb_r <= w_strb_nxt;
    end
  end

  // ***********************************
  // control registers
  // ***********************************
  gppc_pins_t latch_r, latch_nxt, dir_r, dir_nxt, fmode_r, fmode_nxt;
  gppc_pins_t fsel_r, fsel_nxt, fext_r, fext_nxt;
  gppc_pins_t otype_r, otype_nxt, pu_r, pu_nxt;
  logic latch_we;

  always_comb begin
    logic [2:0] bpin;
    logic bval;
    gppc_pins_t wv;
    gppc_pins_t bmask;
    bpin = w_data_r[`GPPC_BIT_PIN_LO +: 3];
    bval = w_data_r[`GPPC_BIT_VAL];
    wv = w_data_r[6:0];
    bmask = 7'h01 << bpin;
    latch_nxt = latch_r;
    dir_nxt = dir_r;
    fmode_nxt = fmode_r;
    fsel_nxt = fsel_r;
    fext_nxt = fext_r;
    otype_nxt = otype_r;
    pu_nxt = pu_r;
    latch_we = 1'b0;
    wr_hit = 1'b1;
    case (aw_addr_r)
      `GPPC_OFS_DATA, `GPPC_OFS_DIR, `GPPC_OFS_FMODE, `GPPC_OFS_FSEL,
      `GPPC_OFS_FEXT, `GPPC_OFS_OTYPE, `GPPC_OFS_PULLUP, `GPPC_OFS_BITOP,
      `GPPC_OFS_PINLVL: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
    if (do_wr & w_strb_r) begin
      case (aw_addr_r)
        `GPPC_OFS_DATA: begin
          latch_nxt = wv; // RULE2
          latch_we = 1'b1;
        end
        `GPPC_OFS_DIR: dir_nxt = wv; // RULE6
        `GPPC_OFS_FMODE: fmode_nxt = wv; // RULE7
        `GPPC_OFS_FSEL: fsel_nxt = wv; // RULE8
        `GPPC_OFS_FEXT: fext_nxt = wv; // RULE9
        `GPPC_OFS_OTYPE: otype_nxt = wv; // RULE10
        `GPPC_OFS_PULLUP: pu_nxt = wv; // RULE12
        `GPPC_OFS_BITOP: begin
          // a pin number of 7 touches nothing
          case (gppc_bsel_e'(w_data_r[`GPPC_BIT_SEL_LO +: 3])) // RULE14
            GPPC_SEL_DATA: begin
              latch_nxt = bval ? (latch_r | bmask) : (latch_r & ~bmask);
              latch_we = 1'b1;
            end
            GPPC_SEL_DIR: dir_nxt = bval ? (dir_r | bmask) : (dir_r & ~bmask);
            GPPC_SEL_FMODE: fmode_nxt = bval ? (fmode_r | bmask) : (fmode_r & ~bmask);
            GPPC_SEL_FSEL: fsel_nxt = bval ? (fsel_r | bmask) : (fsel_r & ~bmask);
            GPPC_SEL_FEXT: fext_nxt = bval ? (fext_r | bmask) : (fext_r & ~bmask);
            GPPC_SEL_OTYPE: otype_nxt = bval ? (otype_r | bmask) : (otype_r & ~bmask);
            GPPC_SEL_PULLUP: pu_nxt = bval ? (pu_r | bmask) : (pu_r & ~bmask);
            default: wr_hit = 1'b1;
          endcase
        end
        default: latch_we = 1'b0;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      latch_r <= `GPPC_RST_DATA;
      dir_r <= `GPPC_RST_DIR; // RULE16
      fmode_r <= `GPPC_RST_ZERO;
      fsel_r <= `GPPC_RST_ZERO;
      fext_r <= `GPPC_RST_ZERO;
      otype_r <= `GPPC_RST_ZERO;
      pu_r <= `GPPC_RST_ZERO;
    end else begin
      latch_r <= latch_nxt; // RULE5
      dir_r <= dir_nxt;
      fmode_r <= fmode_nxt;
      fsel_r <= fsel_nxt;
      fext_r <= fext_nxt;
      otype_r <= otype_nxt;
      pu_r <= pu_nxt;
    end
  end

  // ***********************************
  // per-pin drive and read-back
  // ***********************************
  gppc_pins_t alt_code0, alt_is_out, alt_val, drv_val, drv_oe, rd_val;

  // each pin of port 0 has one function, reached with selection code 00
  assign alt_code0 = ~fsel_r & ~fext_r; // RULE9
  assign alt_is_out = {5'h00, alt_code0[1:0]}; // RULE17
  assign alt_val = {5'h00, TMR_H_OUT & alt_code0[1:0]}; // RULE8

  genvar gi;
  generate
    for (gi = 0; gi < 7; gi++) begin : g_pin // RULE15
      gppc_pin u_pin (
        .latch(latch_r[gi]),
        .dir(dir_r[gi]),
        .fmode(fmode_r[gi]),
        .otype(otype_r[gi]),
        .alt_is_out(alt_is_out[gi]),
        .alt_val(alt_val[gi]),
        .pin_lvl(pin_s_r[gi]),
        .drv_val(drv_val[gi]),
        .drv_oe(drv_oe[gi]),
        .rd_val(rd_val[gi])
      );
    end
  endgenerate

  // ***********************************
  // pin and alternate outputs
  // ***********************************
  gppc_pins_t pin_out_r, pin_oe_r, pin_pu_r;
  logic nmi_r, nmi_nxt;
  logic [3:0] irq_r, irq_nxt;

  always_comb begin
    nmi_nxt = fmode_r[2] & alt_code0[2] & pin_s_r[2]; // RULE17
    irq_nxt = fmode_r[6:3] & alt_code0[6:3] & pin_s_r[6:3];
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      pin_out_r <= `GPPC_RST_ZERO;
      pin_oe_r <= `GPPC_RST_OE; // RULE16
      pin_pu_r <= `GPPC_RST_ZERO;
      nmi_r <= 1'b0;
      irq_r <= 4'h0;
    end else begin
      pin_out_r <= drv_val; // RULE1
      pin_oe_r <= drv_oe;
      pin_pu_r <= pu_r; // RULE12
      nmi_r <= nmi_nxt;
      irq_r <= irq_nxt;
    end
  end

  // ***********************************
  // read channel
  // ***********************************
  logic arready_r, arready_nxt, rvalid_r, rvalid_nxt;
  logic [1:0] rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;

  always_comb begin
    gppc_pins_t rv;
    rv = `GPPC_RST_ZERO;
    rresp_nxt = rresp_r;
    rdata_nxt = rdata_r;
    rvalid_nxt = rvalid_r & ~RREADY;
    if (ARVALID & arready_r) begin
      rresp_nxt = `GPPC_RESP_OKAY;
      case (ARADDR)
        `GPPC_OFS_DATA: rv = rd_val; // RULE3
        `GPPC_OFS_DIR: rv = dir_r;
        `GPPC_OFS_FMODE: rv = fmode_r;
        `GPPC_OFS_FSEL: rv = fsel_r;
        `GPPC_OFS_FEXT: rv = fext_r;
        `GPPC_OFS_OTYPE: rv = otype_r;
        `GPPC_OFS_PULLUP: rv = pu_r;
        `GPPC_OFS_BITOP: rv = `GPPC_RST_ZERO;
        `GPPC_OFS_PINLVL: rv = pin_s_r; // RULE18
        default: rresp_nxt = `GPPC_RESP_SLVERR;
      endcase
      rdata_nxt = {25'h0000000, rv};
      rvalid_nxt = 1'b1;
    end
    // one read at a time
    arready_nxt = ~rvalid_nxt;
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rresp_r <= `GPPC_RESP_OKAY;
      rdata_r <= 32'h0000_0000;
    end else begin
      arready_r <= arready_nxt;
      rvalid_r <= rvalid_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign AWREADY = awready_r;
  assign WREADY = wready_r;
  assign BVALID = bvalid_r;
  assign BRESP = bresp_r;
  assign ARREADY = arready_r;
  assign RVALID = rvalid_r;
  assign RRESP = rresp_r;
  assign RDATA = rdata_r;
  assign PIN_OUT = pin_out_r;
  assign PIN_OE = pin_oe_r;
  assign PIN_PULLUP = pin_pu_r;
  assign NMI_IN = nmi_r;
  assign EXT_IRQ_IN = irq_r;

  // ***********************************
  // assertions
  // ***********************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  gppc_pins_t port_drv;
  assign port_drv = ~fmode_r & ~dir_r & ~otype_r;

  sequence wr_pair_s;
    aw_held_r & w_held_r;
  endsequence
  sequence wr_answer_s;
    BVALID ##0 (aw_held_r == 1'b0);
  endsequence

  latch_hold_a: assert property (!latch_we |=> latch_r == $past(latch_r)) // RULE5
    else $error("latch changed without a write");
  // the pin register lags the control registers by exactly one edge
  port_drive_a: assert property (RST_N |=> ((PIN_OUT & $past(port_drv)) ==
    ($past(latch_r) & $past(port_drv)))) // RULE1
    else $error("port output differs from latch");
  input_float_a: assert property (1'b1 |=> (PIN_OE & $past(dir_r)) == 7'h00) // RULE2
    else $error("input pin is driven");
  open_drain_a: assert property (1'b1 |=> (PIN_OUT & $past(otype_r & ~dir_r)) == 7'h00) // RULE10
    else $error("open drain pin drives high");
  pullup_map_a: assert property (1'b1 |=> PIN_PULLUP == $past(pu_r)) // RULE12
    else $error("pull-up output wrong");
  // the synchroniser still sits in reset on the release edge itself
  pin_sync_a: assert property (RST_N |=> ##1 pin_s_r == $past(PIN_IN, 2)) // RULE18
    else $error("pin level not two stages late");
  nmi_route_a: assert property (fmode_r[2] & alt_code0[2] |=> NMI_IN == $past(pin_s_r[2])) // RULE17
    else $error("nmi routing wrong");
  read_data_a: assert property (ARVALID & arready_r & (ARADDR == `GPPC_OFS_DATA)
    |=> RVALID && RDATA[6:0] == $past(rd_val)) // RULE3
    else $error("port data read wrong");
  wr_answer_a: assert property (wr_pair_s |=> wr_answer_s) // RULE14
    else $error("write answer late");
  reset_pin0_a: assert property (@(posedge CLK) !$past(RST_N) |->
    PIN_OE == `GPPC_RST_OE && !PIN_OUT[0]) // RULE16
    else $error("pin 0 not low after reset");
endmodule

`default_nettype wire

/* rtl/gppc_cfg.svh */
/*
 * address map, reset values and bus codes of the port pin control block.
 * assumes a byte-addressed AXI4-Lite slave with 32-bit data.
 */
`ifndef GPPC_CFG_SVH
`define GPPC_CFG_SVH

// ***********************************
// register byte offsets
// ***********************************
`define GPPC_OFS_DATA 8'h00
`define GPPC_OFS_DIR 8'h04
`define GPPC_OFS_FMODE 8'h08
`define GPPC_OFS_FSEL 8'h0c
`define GPPC_OFS_FEXT 8'h10
`define GPPC_OFS_OTYPE 8'h14
`define GPPC_OFS_PULLUP 8'h18
`define GPPC_OFS_BITOP 8'h1c
`define GPPC_OFS_PINLVL 8'h20

// ***********************************
// reset values
// ***********************************
`define GPPC_RST_DATA 7'h00
`define GPPC_RST_DIR 7'h7e
`define GPPC_RST_ZERO 7'h00
`define GPPC_RST_OE 7'h01

// ***********************************
// bit operation word fields
// ***********************************
`define GPPC_BIT_PIN_LO 0
`define GPPC_BIT_SEL_LO 4
`define GPPC_BIT_VAL 8

// ***********************************
// bus answers
// ***********************************
`define GPPC_RESP_OKAY 2'h0
`define GPPC_RESP_SLVERR 2'h2

`endif

/* rtl/gppc_pkg.sv */
/*
 * types shared by the port pin control block.
 * assumes gppc_cfg.svh holds the numbers.
 */
`default_nettype none

package gppc_pkg;
  typedef logic [6:0] gppc_pins_t;
  typedef logic [7:0] gppc_addr_t;
  // target register of a single-bit write
  typedef enum logic [2:0] {
    GPPC_SEL_DATA,
    GPPC_SEL_DIR,
    GPPC_SEL_FMODE,
    GPPC_SEL_FSEL,
    GPPC_SEL_FEXT,
    GPPC_SEL_OTYPE,
    GPPC_SEL_PULLUP
  } gppc_bsel_e;
endpackage

`default_nettype wire

/* rtl/gppc_pin.sv */
/*
 * drive and read-back logic of one port pin, purely combinational.
 * assumes the caller registers the results and feeds synchronised pin levels.
 */
`default_nettype none

module gppc_pin (
  // control bits
  input wire logic latch,
  input wire logic dir,
  input wire logic fmode,
  input wire logic otype,
  // alternate function
  input wire logic alt_is_out,
  input wire logic alt_val,
  // pin
  input wire logic pin_lvl,
  output logic drv_val,
  output logic drv_oe,
  output logic rd_val
);
  logic src;

  always_comb begin
    // alternate input function in output mode leaves the pin undriven
    src = fmode ? alt_val : latch; // RULE4
    drv_oe = ~dir & (~fmode | alt_is_out); // RULE1
    drv_val = src;
    if (~dir & otype) begin // RULE11
      // open drain: only pull low, release for a one
      drv_oe = drv_oe & ~src; // RULE10
      drv_val = 1'b0;
    end
    if (dir) begin
      rd_val = pin_lvl; // RULE2
    end else if (fmode & alt_is_out) begin
      rd_val = alt_val; // RULE3
    end else begin
      rd_val = latch; // RULE1
    end
  end
endmodule

`default_nettype wire

/* dv/gppc_pads.sv */
/*
 * external devices on the seven port 0 pins.
 * assumes the bench picks which pins it drives and at what level.
 */
`default_nettype none

module gppc_pads (
  // clock
  input wire logic clk,
  // design side
  input wire gppc_pkg::gppc_pins_t pin_out,
  input wire gppc_pkg::gppc_pins_t pin_oe,
  input wire gppc_pkg::gppc_pins_t pin_pullup,
  // bench side
  input wire gppc_pkg::gppc_pins_t ext_val,
  input wire gppc_pkg::gppc_pins_t ext_en,
  // resolved levels
  output gppc_pkg::gppc_pins_t pin_lvl
);
  timeunit 1ns;
  timeprecision 100ps;
  import gppc_pkg::*;

  // ***********************************
  // wire resolution
  // ***********************************
  gppc_pins_t last_r = 7'h00;

  // a floating line flips each cycle, so a missed drive cannot read back by luck
  always_ff @(posedge clk) begin
    last_r <= pin_lvl;
  end

  always_comb begin
    for (int i = 0; i < 7; i++) begin
      pin_lvl[i] = pin_oe[i] ? pin_out[i] : ext_en[i] ? ext_val[i] :
                   pin_pullup[i] ? 1'h1 : ~last_r[i];
    end
  end
endmodule

`default_nettype wire

/* dv/gppc_port0_test.sv */
/*
 * register-level bench of port 0.
 * assumes gppc_cfg.svh offsets and the pad model in gppc_pads.
 */
`include "gppc_cfg.svh"
`default_nettype none

module gppc_port0_test;
  timeunit 1ns;
  timeprecision 100ps;
  import gppc_pkg::*;

  // ***********************************
  // signals
  // ***********************************
  logic CLK, RST_N, AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
  logic ARVALID, ARREADY, RVALID, RREADY, NMI_IN;
  gppc_addr_t AWADDR, ARADDR;
  logic [31:0] WDATA, RDATA, rd;
  logic [3:0] WSTRB, EXT_IRQ_IN;
  logic [1:0] BRESP, RRESP, TMR_H_OUT, rs;
  gppc_pins_t PIN_IN, PIN_OUT, PIN_OE, PIN_PULLUP, ext_val, ext_en;
  int bad_count = 0;
  int tests_run = 0;

  gppc_port0 i_gppc_port0 (.CLK(CLK), .RST_N(RST_N), .AWADDR(AWADDR), .AWVALID(AWVALID),
    .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY),
    .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
    .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
    .PIN_IN(PIN_IN), .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE), .PIN_PULLUP(PIN_PULLUP),
    .TMR_H_OUT(TMR_H_OUT), .NMI_IN(NMI_IN), .EXT_IRQ_IN(EXT_IRQ_IN));

  gppc_pads i_gppc_pads (.clk(CLK), .pin_out(PIN_OUT), .pin_oe(PIN_OE),
    .pin_pullup(PIN_PULLUP), .ext_val(ext_val), .ext_en(ext_en), .pin_lvl(PIN_IN));

  initial begin
    CLK = 1'h0;
    forever #2 CLK = ~CLK;
  end

  // ***********************************
  // tasks
  // ***********************************
  task automatic final_report;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // address and data go out together and drop one by one as each is taken
  task automatic wr(input gppc_addr_t a, input logic [31:0] d, input logic [3:0] s,
                    output logic [1:0] r);
    int n;
    @(posedge CLK);
    AWADDR <= a;
    WDATA <= d;
    WSTRB <= s;
    AWVALID <= 1'h1;
    WVALID <= 1'h1;
    BREADY <= 1'h1;
    n = 0;
    do begin
      @(posedge CLK);
      n++;
      if (AWVALID && AWREADY) AWVALID <= 1'h0;
      if (WVALID && WREADY) WVALID <= 1'h0;
    end while (!BVALID && n < 40);
    if (BVALID !== 1'h1) begin
      bad_count++;
      final_report;
    end
    r = BRESP;
    BREADY <= 1'h0;
  endtask

  task automatic rd_reg(input gppc_addr_t a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge CLK);
    ARADDR <= a;
    ARVALID <= 1'h1;
    RREADY <= 1'h1;
    n = 0;
    do begin
      @(posedge CLK);
      n++;
      if (ARVALID && ARREADY) ARVALID <= 1'h0;
    end while (!RVALID && n < 40);
    if (RVALID !== 1'h1) begin
      bad_count++;
      final_report;
    end
    d = RDATA;
    r = RRESP;
    RREADY <= 1'h0;
  endtask

  task automatic wreg(input gppc_addr_t a, input logic [31:0] d);
    wr(a, d, 4'hf, rs);
  endtask

  task automatic rchk(input gppc_addr_t a, input logic [31:0] e);
    rd_reg(a, rd, rs);
    chk(rd, e);
  endtask

  // four edges cover the pin output register, the two-flop synchroniser and the routed-input register
  task automatic settle;
    repeat (4) @(posedge CLK);
    #1;
  endtask

  task automatic pins(input gppc_pins_t v, input gppc_pins_t e, input logic [1:0] t);
    @(posedge CLK);
    ext_val <= v;
    ext_en <= e;
    TMR_H_OUT <= t;
  endtask

  // ***********************************
  // sequence
  // ***********************************
  initial begin
    RST_N = 1'h0;
    {AWVALID, WVALID, BREADY, ARVALID, RREADY} = 5'h00;
    AWADDR = 8'h00;
    ARADDR = 8'h00;
    WDATA = 32'h0;
    WSTRB = 4'h0;
    TMR_H_OUT = 2'h0;
    ext_val = 7'h2a;
    ext_en = 7'h7e;
    repeat (2) @(posedge CLK);
    RST_N <= 1'h1;
    repeat (2) @(posedge CLK);
    #1;
    chk(32'(PIN_OE), 32'h01);
    chk(32'(PIN_OUT), 32'h00);
    chk(32'(PIN_PULLUP), 32'h00);
    rchk(`GPPC_OFS_DIR, 32'h7e);
    rchk(`GPPC_OFS_OTYPE, 32'h00);
    rchk(`GPPC_OFS_PULLUP, 32'h00);
    rchk(`GPPC_OFS_FMODE, 32'h00);
    rchk(`GPPC_OFS_DATA, 32'h2a);
    wreg(`GPPC_OFS_DATA, 32'h55);
    settle;
    chk(32'(PIN_OUT & PIN_OE), 32'h01);
    chk(32'(PIN_OE), 32'h01);
    rchk(`GPPC_OFS_DATA, 32'h2b);
    pins(7'h2a, 7'h00, 2'h2);
    wreg(`GPPC_OFS_DIR, 32'h00);
    settle;
    chk(32'(PIN_OE), 32'h7f);
    chk(32'(PIN_OUT), 32'h55);
    rchk(`GPPC_OFS_DATA, 32'h55);
    wreg(`GPPC_OFS_OTYPE, 32'h03);
    settle;
    chk(32'(PIN_OE), 32'h7e);
    chk(32'(PIN_OUT), 32'h54);
    wreg(`GPPC_OFS_DIR, 32'h02);
    settle;
    chk(32'(PIN_OE), 32'h7c);
    wreg(`GPPC_OFS_DIR, 32'h00);
    wreg(`GPPC_OFS_OTYPE, 32'h00);
    // selection first, then mode
    wreg(`GPPC_OFS_FSEL, 32'h00);
    wreg(`GPPC_OFS_FEXT, 32'h00);
    wreg(`GPPC_OFS_FMODE, 32'h03);
    settle;
    chk(32'(PIN_OUT), 32'h56);
    rchk(`GPPC_OFS_DATA, 32'h56);
    wreg(`GPPC_OFS_DATA, 32'h00);
    settle;
    chk(32'(PIN_OUT), 32'h02);
    rchk(`GPPC_OFS_DATA, 32'h02);
    pins(7'h54, 7'h7c, 2'h1);
    wreg(`GPPC_OFS_DIR, 32'h7c);
    wreg(`GPPC_OFS_FMODE, 32'h7f);
    settle;
    chk(32'(PIN_OUT[1:0]), 32'h1);
    chk(32'(NMI_IN), 32'h1);
    chk(32'(EXT_IRQ_IN), 32'ha);
    rchk(`GPPC_OFS_DATA, 32'h55);
    rchk(`GPPC_OFS_PINLVL, 32'h55);
    pins(7'h54, 7'h00, 2'h1);
    wreg(`GPPC_OFS_DATA, 32'h04);
    wreg(`GPPC_OFS_DIR, 32'h00);
    settle;
    chk(32'(PIN_OE), 32'h03);
    rchk(`GPPC_OFS_DATA, 32'h05);
    wreg(`GPPC_OFS_FSEL, 32'h01);
    wreg(`GPPC_OFS_FEXT, 32'h40);
    rchk(`GPPC_OFS_FSEL, 32'h01);
    rchk(`GPPC_OFS_FEXT, 32'h40);
    // data last, once direction and mode are back to plain output
    for (int k = 6; k >= 0; k--) begin
      wreg(8'(4 * k), 32'h00);
      wreg(`GPPC_OFS_BITOP, 32'((1 << `GPPC_BIT_VAL) | (k << `GPPC_BIT_SEL_LO) | 5));
      rchk(8'(4 * k), 32'h20);
      wreg(`GPPC_OFS_BITOP, 32'((k << `GPPC_BIT_SEL_LO) | (5 << `GPPC_BIT_PIN_LO)));
      rchk(8'(4 * k), 32'h00);
    end
    wreg(`GPPC_OFS_PULLUP, 32'h7f);
    settle;
    chk(32'(PIN_PULLUP), 32'h7f);
    wr(8'h40, 32'h7f, 4'hf, rs);
    chk(32'(rs), 32'(`GPPC_RESP_SLVERR));
    rd_reg(8'h40, rd, rs);
    chk(32'(rs), 32'(`GPPC_RESP_SLVERR));
    chk(rd, 32'h0);
    wr(`GPPC_OFS_DIR, 32'h7f, 4'he, rs);
    chk(32'(rs), 32'(`GPPC_RESP_OKAY));
    rchk(`GPPC_OFS_DIR, 32'h00);
    @(posedge CLK);
    RST_N <= 1'h0;
    repeat (2) @(posedge CLK);
    #1;
    chk(32'(PIN_OE), 32'h01);
    chk(32'(PIN_PULLUP), 32'h00);
    final_report;
  end
endmodule

`default_nettype wire
